// ==== design/fcd_device.sv ====
// Command decoder and phase sequencer of the floppy controller
//
// Notes on behaviour
// RL1: scan high-or-equal: opcode xxx11101, eight parameters
// RL2: scan low-or-equal: opcode xxx11001, eight parameters
// RL3: scans compare host against disk, seven results
// RL4: seek takes drive, track, nibble if extended
// RL5: seek steps head to target, no results
// RL6: sense drive status returns drive status byte
// RL7: sense interrupt returns status, track, nibble if extended
// RL8: set track reads or writes present track
// RL9: specify stores step, motor times, mode; silent
// RL10: verify reads disk only, seven results
// RL11: write data takes host bytes to disk
// RL12: second byte: implied seek, head, drive
// RL13: pending results set status bits 7, 6
// RL14: host finishes each phase before next opcode
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "fcd_defs.svh"
`default_nettype none
module fcd_device #(
  parameter int STEP_UNIT_CYC = `FCD_STEP_UNIT_NS / `FCD_CLK_NS,
  parameter int MAX_SIZE_CODE = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the host side
  fcd_link_if.dev link,
  // Drive control and status pins
  output logic [1:0] drive_sel,
  output logic head_sel,
  output logic step_pulse,
  output logic step_inward,
  input wire logic drv_write_protect,
  input wire logic drv_ready,
  input wire logic drv_track0,
  // Disk data stream
  input wire logic disk_rd_valid,
  input wire logic [7:0] disk_rd_data,
  output logic disk_rd_ready,
  output logic disk_wr_valid,
  output logic [7:0] disk_wr_data
);
  if (MAX_SIZE_CODE > 7 || STEP_UNIT_CYC < 1) begin : g_chk
    $error("fcd_device: parameter out of range");
  end

  // Opcode decode
  function automatic fcd_pkg::fcd_cmd_e decode(input logic [7:0] op);
    logic [7:0] lo;
    lo = op & `FCD_OP_LOW5_MASK;
    if (lo == `FCD_OP_SCAN_HE) return fcd_pkg::CMD_SCAN_HE; // RL1
    if (lo == `FCD_OP_SCAN_LE) return fcd_pkg::CMD_SCAN_LE; // RL2
    if (lo == `FCD_OP_VERIFY) return fcd_pkg::CMD_VERIFY; // RL10
    if (lo == `FCD_OP_WRITE && op[5] == 1'b0) return fcd_pkg::CMD_WRITE; // RL11
    if (op == `FCD_OP_SEEK) return fcd_pkg::CMD_SEEK; // RL4
    if (op == `FCD_OP_SENSE_DRV) return fcd_pkg::CMD_SENSE_DRV; // RL6
    if (op == `FCD_OP_SENSE_INT) return fcd_pkg::CMD_SENSE_INT; // RL7
    if (op == `FCD_OP_SPECIFY) return fcd_pkg::CMD_SPECIFY; // RL9
    if ((op & `FCD_OP_SET_TRK_MASK) == `FCD_OP_SET_TRK) return fcd_pkg::CMD_SET_TRK; // RL8
    return fcd_pkg::CMD_INVALID;
  endfunction

  // Parameter bytes that follow the opcode
  function automatic logic [3:0] param_need(input fcd_pkg::fcd_cmd_e c, input logic extended_track_range);
    unique case (c)
      fcd_pkg::CMD_SCAN_HE, fcd_pkg::CMD_SCAN_LE, fcd_pkg::CMD_VERIFY,
      fcd_pkg::CMD_WRITE: return `FCD_DISK_PARAMS; // RL1 RL2
      fcd_pkg::CMD_SEEK: return extended_track_range ? 4'h3 : 4'h2; // RL4
      fcd_pkg::CMD_SENSE_DRV: return 4'h1;
      fcd_pkg::CMD_SET_TRK, fcd_pkg::CMD_SPECIFY: return 4'h2;
      fcd_pkg::CMD_SENSE_INT, fcd_pkg::CMD_INVALID: return 4'h0;
    endcase
  endfunction

  fcd_pkg::fcd_state_e state_r;
  fcd_pkg::fcd_cmd_e cmd_r;
  logic [7:0] par_r [0:8];
  logic [7:0] res_r [0:6];
  logic [11:0] ptr_r [0:3];
  logic [3:0] pidx_r, pneed_r;
  logic [2:0] ridx_r, rlen_r;
  logic [3:0] srt_r, mot_off_r;
  logic [6:0] mot_on_r;
  logic non_dma_r, int_pend_r, ret_exec_r, have_h_r, hit_r, notsat_r;
  logic [7:0] st0_int_r, hbuf_r;
  logic [11:0] target_r;
  logic [31:0] step_tmr_r;
  logic [15:0] bytes_left_r;
  logic [7:0] secs_left_r;
  logic [2:0] sync1_r, sync2_r;

  // Second byte fields of the current command
  logic [1:0] drv;
  logic hd, need_host, need_disk, h_ok, byte_done, last_byte;
  logic [15:0] sec_bytes;
  logic [7:0] st3, st0_norm;
  assign drv = par_r[1][1:0]; // RL12
  assign hd = par_r[1][2]; // RL12
  assign need_host = cmd_r inside {fcd_pkg::CMD_WRITE, fcd_pkg::CMD_SCAN_HE, fcd_pkg::CMD_SCAN_LE};
  assign need_disk = cmd_r inside {fcd_pkg::CMD_VERIFY, fcd_pkg::CMD_SCAN_HE, fcd_pkg::CMD_SCAN_LE};
  assign sec_bytes = `FCD_SECTOR_BASE << par_r[5][2:0];
  assign st3 = {1'b0, sync2_r[2], sync2_r[1], sync2_r[0], 1'b0, hd, drv}; // RL6
  assign st0_norm = {5'h00, hd, drv};

  // Drive status pins pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {drv_write_protect, drv_ready, drv_track0};
      sync2_r <= sync1_r;
    end
  end

  // Exec phase byte movement; scans wait for the host byte before the disk byte
  assign h_ok = have_h_r || !need_host;
  assign disk_rd_ready = (state_r == fcd_pkg::ST_EXEC) && need_disk && h_ok;
  assign byte_done = (state_r == fcd_pkg::ST_EXEC) &&
                     (need_disk ? (disk_rd_valid && h_ok) : have_h_r);
  assign last_byte = (bytes_left_r == 16'h0001) && (secs_left_r == 8'h01);

  // Main status register image
  always_comb begin
    link.main_status = 8'h00;
    link.main_status[`FCD_MSR_RQM] = (state_r == fcd_pkg::ST_OPCODE) ||
      (state_r == fcd_pkg::ST_PARAM) || (state_r == fcd_pkg::ST_RESULT) || // RL13
      ((state_r == fcd_pkg::ST_EXEC) && need_host && !have_h_r && non_dma_r);
    link.main_status[`FCD_MSR_DIO] = (state_r == fcd_pkg::ST_RESULT); // RL13
    link.main_status[`FCD_MSR_NDMA] = (state_r == fcd_pkg::ST_EXEC) && non_dma_r;
    link.main_status[`FCD_MSR_BUSY] = (state_r != fcd_pkg::ST_OPCODE);
    if (state_r == fcd_pkg::ST_SEEK) link.main_status[drv] = 1'b1;
  end
  // DMA requests replace the status request when DMA mode is chosen
  assign link.dma_req = (state_r == fcd_pkg::ST_EXEC) && need_host && !have_h_r && !non_dma_r; // RL11
  assign link.rd_data = res_r[ridx_r];
  assign link.int_pending = int_pend_r;
  assign drive_sel = drv;
  assign head_sel = hd;

  // Phase sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= fcd_pkg::ST_OPCODE;
      cmd_r <= fcd_pkg::CMD_INVALID;
      for (int i = 0; i < 9; i++) par_r[i] <= 8'h00;
      for (int i = 0; i < 7; i++) res_r[i] <= 8'h00;
      for (int i = 0; i < 4; i++) ptr_r[i] <= 12'h000;
      pidx_r <= 4'h0;
      pneed_r <= 4'h0;
      ridx_r <= 3'h0;
      rlen_r <= 3'h0;
      srt_r <= 4'h0;
      mot_off_r <= 4'h0;
      mot_on_r <= 7'h00;
      non_dma_r <= 1'b0;
      int_pend_r <= 1'b0;
      st0_int_r <= 8'h00;
      ret_exec_r <= 1'b0;
      target_r <= 12'h000;
      step_tmr_r <= 32'h0;
      step_pulse <= 1'b0;
      step_inward <= 1'b0;
      have_h_r <= 1'b0;
      hbuf_r <= 8'h00;
      hit_r <= 1'b0;
      notsat_r <= 1'b0;
      bytes_left_r <= 16'h0000;
      secs_left_r <= 8'h00;
      disk_wr_valid <= 1'b0;
      disk_wr_data <= 8'h00;
    end else begin
      step_pulse <= 1'b0;
      disk_wr_valid <= 1'b0;
      unique case (state_r)
        fcd_pkg::ST_OPCODE: if (link.byte_wr) begin
          cmd_r <= decode(link.wr_data);
          par_r[0] <= link.wr_data;
          pneed_r <= param_need(decode(link.wr_data), link.extended_track_range);
          pidx_r <= 4'h1;
          ridx_r <= 3'h0;
          if (decode(link.wr_data) == fcd_pkg::CMD_SENSE_INT) begin
            // No pending event answers as an invalid command
            res_r[0] <= int_pend_r ? st0_int_r : `FCD_ST0_INVALID; // RL7
            res_r[1] <= ptr_r[drv][7:0]; // RL7
            res_r[2] <= {ptr_r[drv][11:8], 4'h0}; // RL7
            rlen_r <= link.extended_track_range ? 3'h3 : 3'h2; // RL7
            int_pend_r <= 1'b0;
            state_r <= fcd_pkg::ST_RESULT;
          end else if (decode(link.wr_data) == fcd_pkg::CMD_INVALID) begin
            res_r[0] <= `FCD_ST0_INVALID;
            rlen_r <= 3'h1;
            state_r <= fcd_pkg::ST_RESULT; // RL13
          end else begin
            state_r <= fcd_pkg::ST_PARAM;
          end
        end
        fcd_pkg::ST_PARAM: if (link.byte_wr) begin
          par_r[pidx_r] <= link.wr_data;
          pidx_r <= pidx_r + 4'h1;
          if (pidx_r == pneed_r) state_r <= fcd_pkg::ST_DISPATCH;
        end
        fcd_pkg::ST_DISPATCH: begin
          unique case (cmd_r)
            fcd_pkg::CMD_SEEK: begin
              target_r <= {(link.extended_track_range ? par_r[3][7:4] : 4'h0), par_r[2]}; // RL4
              ret_exec_r <= 1'b0;
              state_r <= fcd_pkg::ST_SEEK;
            end
            fcd_pkg::CMD_SENSE_DRV: begin
              res_r[0] <= st3; // RL6
              rlen_r <= 3'h1;
              state_r <= fcd_pkg::ST_RESULT;
            end
            fcd_pkg::CMD_SET_TRK: begin
              // Upper byte select reaches the high nibble of the track
              if (par_r[0][`FCD_WNR_BIT] && par_r[1][2]) ptr_r[drv][11:8] <= par_r[2][3:0]; // RL8
              if (par_r[0][`FCD_WNR_BIT] && !par_r[1][2]) ptr_r[drv][7:0] <= par_r[2]; // RL8
              res_r[0] <= par_r[0][`FCD_WNR_BIT] ? par_r[2] :
                          (par_r[1][2] ? {4'h0, ptr_r[drv][11:8]} : ptr_r[drv][7:0]); // RL8
              rlen_r <= 3'h1;
              state_r <= fcd_pkg::ST_RESULT;
            end
            fcd_pkg::CMD_SPECIFY: begin
              srt_r <= par_r[1][7:4]; // RL9
              mot_off_r <= par_r[1][3:0]; // RL9
              mot_on_r <= par_r[2][7:1]; // RL9
              non_dma_r <= par_r[2][0]; // RL9
              state_r <= fcd_pkg::ST_OPCODE;
            end
            fcd_pkg::CMD_SENSE_INT, fcd_pkg::CMD_INVALID: state_r <= fcd_pkg::ST_OPCODE;
            default: begin
              bytes_left_r <= sec_bytes;
              // Sector count mode of verify covers several sectors
              secs_left_r <= (cmd_r == fcd_pkg::CMD_VERIFY && par_r[1][7] && par_r[8] != 8'h00) ?
                             par_r[8] : 8'h01; // RL10
              hit_r <= 1'b1;
              notsat_r <= 1'b0;
              have_h_r <= 1'b0;
              target_r <= {ptr_r[drv][11:8], par_r[2]};
              ret_exec_r <= 1'b1;
              if (cmd_r != fcd_pkg::CMD_VERIFY && par_r[1][7] && par_r[2] != ptr_r[drv][7:0])
                state_r <= fcd_pkg::ST_SEEK; // RL12
              else
                state_r <= fcd_pkg::ST_EXEC;
            end
          endcase
        end
        fcd_pkg::ST_SEEK: begin
          if (ptr_r[drv] == target_r) begin
            if (ret_exec_r) begin
              state_r <= fcd_pkg::ST_EXEC;
            end else begin
              st0_int_r <= st0_norm | (8'h01 << `FCD_ST0_SEEK_END); // RL5
              int_pend_r <= 1'b1;
              state_r <= fcd_pkg::ST_OPCODE; // RL5
            end
          end else if (step_tmr_r != 32'h0) begin
            step_tmr_r <= step_tmr_r - 32'h1;
          end else begin
            // Slower stepping for lower rate codes
            step_tmr_r <= 32'(16 - int'(srt_r)) * 32'(STEP_UNIT_CYC);
            step_pulse <= 1'b1; // RL5
            step_inward <= target_r > ptr_r[drv];
            ptr_r[drv] <= (target_r > ptr_r[drv]) ? ptr_r[drv] + 12'h001 : ptr_r[drv] - 12'h001;
          end
        end
        fcd_pkg::ST_EXEC: begin
          if (need_host && !have_h_r && link.byte_wr) begin
            hbuf_r <= link.wr_data; // RL11
            have_h_r <= 1'b1;
          end
          if (byte_done) begin
            have_h_r <= 1'b0;
            if (cmd_r == fcd_pkg::CMD_WRITE) begin
              disk_wr_valid <= 1'b1; // RL11
              disk_wr_data <= hbuf_r;
            end
            if (need_host && need_disk) begin
              if (disk_rd_data != hbuf_r) hit_r <= 1'b0; // RL3
              if (cmd_r == fcd_pkg::CMD_SCAN_HE ? disk_rd_data < hbuf_r
                                                : disk_rd_data > hbuf_r)
                notsat_r <= 1'b1; // RL3
            end
            if (last_byte) begin
              res_r[0] <= st0_norm; // RL3 RL10 RL11
              res_r[1] <= 8'h00;
              // Equality bit only means something for scans
              res_r[2] <= {4'h0, hit_r && disk_rd_data == hbuf_r && need_host && need_disk,
                           notsat_r, 2'h0};
              res_r[3] <= par_r[2];
              res_r[4] <= par_r[3];
              res_r[5] <= par_r[4];
              res_r[6] <= par_r[5];
              rlen_r <= `FCD_DISK_RESULTS;
              st0_int_r <= st0_norm;
              int_pend_r <= 1'b1;
              state_r <= fcd_pkg::ST_RESULT; // RL13
            end else if (bytes_left_r == 16'h0001) begin
              bytes_left_r <= sec_bytes;
              secs_left_r <= secs_left_r - 8'h01;
            end else begin
              bytes_left_r <= bytes_left_r - 16'h0001;
            end
          end
        end
        fcd_pkg::ST_RESULT: if (link.byte_rd) begin
          ridx_r <= ridx_r + 3'h1;
          if (ridx_r == rlen_r - 3'h1) state_r <= fcd_pkg::ST_OPCODE; // RL13
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== design/fcd_defs.svh ====
// Constants of the floppy command decoder and its host-side controller
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH
// Opcode patterns
`define FCD_OP_LOW5_MASK 8'h1F
`define FCD_OP_SCAN_HE 8'h1D
`define FCD_OP_SCAN_LE 8'h19
`define FCD_OP_VERIFY 8'h16
`define FCD_OP_WRITE 8'h05
`define FCD_OP_SEEK 8'h0F
`define FCD_OP_SENSE_DRV 8'h04
`define FCD_OP_SENSE_INT 8'h08
`define FCD_OP_SPECIFY 8'h03
`define FCD_OP_SET_TRK 8'h21
`define FCD_OP_SET_TRK_MASK 8'hBF
`define FCD_WNR_BIT 6
// Parameter and result byte counts
`define FCD_DISK_PARAMS 4'h8
`define FCD_DISK_RESULTS 3'h7
// Main status register bits
`define FCD_MSR_RQM 7
`define FCD_MSR_DIO 6
`define FCD_MSR_NDMA 5
`define FCD_MSR_BUSY 4
// Status byte values and bits
`define FCD_ST0_INVALID 8'h80
`define FCD_ST0_SEEK_END 5
`define FCD_ST2_SCAN_HIT 3
`define FCD_ST2_SCAN_NOT 2
// Base sector size, 128 bytes shifted by the size code
`define FCD_SECTOR_BASE 16'h0080
// Timing
`define FCD_CLK_NS 20
`define FCD_STEP_UNIT_NS 500000
// Host register offsets
`define FCD_REG_DATA 8'h00
`define FCD_REG_STATUS 8'h04
`define FCD_REG_IRQ_STAT 8'h08
`define FCD_REG_IRQ_MASK 8'h0C
`define FCD_REG_CFG 8'h10
// Interrupt status bits
`define FCD_IRQ_RESULT 0
`define FCD_IRQ_CMD_REQ 1
`define FCD_IRQ_DEV_INT 2
`define FCD_IRQ_REFUSED 3
`endif

// ==== design/fcd_pkg.sv ====
// Types used by the command decoder end of the floppy command link
package fcd_pkg;
  typedef enum logic [3:0] {
    CMD_SCAN_HE, CMD_SCAN_LE, CMD_SEEK, CMD_SENSE_DRV, CMD_SENSE_INT,
    CMD_SET_TRK, CMD_SPECIFY, CMD_VERIFY, CMD_WRITE, CMD_INVALID
  } fcd_cmd_e;
  typedef enum logic [2:0] {
    ST_OPCODE, ST_PARAM, ST_DISPATCH, ST_SEEK, ST_EXEC, ST_RESULT
  } fcd_state_e;
endpackage

// ==== design/fcd_link_if.sv ====
// Byte link between the host-side controller and the command decoder
`timescale 1ns/1ps
`default_nettype none
interface fcd_link_if;
  logic byte_wr;
  logic [7:0] wr_data;
  logic byte_rd;
  logic [7:0] rd_data;
  logic [7:0] main_status;
  logic dma_req;
  logic int_pending;
  logic extended_track_range;
  modport dev (input byte_wr, wr_data, byte_rd, extended_track_range,
               output rd_data, main_status, dma_req, int_pending);
  modport host (output byte_wr, wr_data, byte_rd, extended_track_range,
                input rd_data, main_status, dma_req, int_pending);
endinterface
`default_nettype wire

// ==== design/fcd_host.sv ====
// Host-side controller: APB registers driving the command byte link
`timescale 1ns/1ps
`include "fcd_defs.svh"
`default_nettype none
module fcd_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Link to the decoder
  fcd_link_if.host link
);
  logic [3:0] irq_stat_r, irq_mask_r;
  logic etr_r, rqm_q_r, res_q_r, int_q_r;
  logic access, done, want_out, want_in, mapped;
  logic [3:0] ev, clr;

  assign access = psel && penable;
  assign done = access && pready;
  // Byte may go out on status request or DMA request; a result may come back
  assign want_out = (link.main_status[`FCD_MSR_RQM] && !link.main_status[`FCD_MSR_DIO])
                    || link.dma_req; // RL14
  assign want_in = link.main_status[`FCD_MSR_RQM] && link.main_status[`FCD_MSR_DIO];
  assign mapped = paddr inside {`FCD_REG_DATA, `FCD_REG_STATUS, `FCD_REG_IRQ_STAT,
                                `FCD_REG_IRQ_MASK, `FCD_REG_CFG};
  assign link.extended_track_range = etr_r;
  assign irq = |(irq_stat_r & irq_mask_r);

  // One wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      if (access && !pready) begin
        unique case (paddr)
          `FCD_REG_DATA: prdata <= {24'h0, want_in ? link.rd_data : 8'h00};
          `FCD_REG_STATUS: prdata <= {22'h0, link.int_pending, link.dma_req, link.main_status};
          `FCD_REG_IRQ_STAT: prdata <= {28'h0, irq_stat_r};
          `FCD_REG_IRQ_MASK: prdata <= {28'h0, irq_mask_r};
          `FCD_REG_CFG: prdata <= {31'h0, etr_r};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // Link strobes, issued at the completing APB edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.byte_wr <= 1'b0;
      link.wr_data <= 8'h00;
      link.byte_rd <= 1'b0;
    end else begin
      link.byte_wr <= done && pwrite && paddr == `FCD_REG_DATA && want_out; // RL14
      link.byte_rd <= done && !pwrite && paddr == `FCD_REG_DATA && want_in; // RL14
      if (done && pwrite && paddr == `FCD_REG_DATA) link.wr_data <= pwdata[7:0];
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= 4'h0;
      etr_r <= 1'b0;
    end else if (done && pwrite) begin
      if (paddr == `FCD_REG_IRQ_MASK) irq_mask_r <= pwdata[3:0];
      if (paddr == `FCD_REG_CFG) etr_r <= pwdata[0];
    end
  end

  // Sticky events; only bits seen by the read are cleared, new events win
  always_comb begin
    ev = 4'h0;
    ev[`FCD_IRQ_RESULT] = want_in && !res_q_r;
    ev[`FCD_IRQ_CMD_REQ] = want_out && !rqm_q_r;
    ev[`FCD_IRQ_DEV_INT] = link.int_pending && !int_q_r;
    ev[`FCD_IRQ_REFUSED] = done && paddr == `FCD_REG_DATA &&
                           (pwrite ? !want_out : !want_in);
    clr = (done && !pwrite && paddr == `FCD_REG_IRQ_STAT) ? prdata[3:0] : 4'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 4'h0;
      rqm_q_r <= 1'b1;
      res_q_r <= 1'b0;
      int_q_r <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
      rqm_q_r <= want_out;
      res_q_r <= want_in;
      int_q_r <= link.int_pending;
    end
  end
endmodule
`default_nettype wire

// ==== bench/fcd_link_monitor.sv ====
// Concurrent checks on the command byte link
`timescale 1ns/1ps
`include "fcd_defs.svh"
`default_nettype none
module fcd_link_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host to decoder
  input wire logic byte_wr,
  input wire logic [7:0] wr_data,
  input wire logic byte_rd,
  input wire logic extended_track_range,
  // Decoder to host
  input wire logic [7:0] rd_data,
  input wire logic [7:0] main_status,
  input wire logic dma_req,
  input wire logic int_pending
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Decoder waiting for an opcode, not busy
  logic op_idle;
  assign op_idle = main_status[7] & ~main_status[6] & ~main_status[4];
  // Opcodes that must be followed by parameter bytes
  logic op_par;
  assign op_par = wr_data == `FCD_OP_SEEK || wr_data == `FCD_OP_SENSE_DRV ||
    wr_data == `FCD_OP_SPECIFY || (wr_data & 8'h1F) == `FCD_OP_SCAN_HE ||
    (wr_data & 8'h1F) == `FCD_OP_SCAN_LE;
  chk_wr_when_asked: assert property (byte_wr |->
    (main_status[7] && !main_status[6]) || dma_req)
    else $error("byte written while decoder not asking");
  chk_rd_in_result: assert property (byte_rd |-> main_status[7:6] == 2'b11)
    else $error("result consumed outside result phase");
  chk_reset_idle: assert property ($rose(presetn) |-> main_status == 8'h80)
    else $error("decoder not idle after reset");
  chk_sense_empty: assert property (byte_wr && op_idle && !int_pending &&
    wr_data == `FCD_OP_SENSE_INT |=> main_status[7:6] == 2'b11 && rd_data == 8'h80)
    else $error("sense interrupt without event gave wrong first result");
  chk_param_wanted: assert property (byte_wr && op_idle && op_par |=>
    main_status[7:6] == 2'b10 && main_status[4])
    else $error("decoder not asking for parameters after opcode");
  chk_result_hold: assert property (main_status[7:6] == 2'b11 && !byte_rd |=> $stable(rd_data))
    else $error("result byte changed before being consumed");
  chk_dma_dir: assert property (dma_req |-> !main_status[6])
    else $error("transfer request while results pending");
  chk_int_clear: assert property (byte_wr && op_idle && int_pending &&
    wr_data == `FCD_OP_SENSE_INT |-> ##[1:3] !int_pending)
    else $error("sense interrupt left event pending");
endmodule
`default_nettype wire

// ==== bench/floppy_command_decoder_test.sv ====
// Self-checking bench: APB host controller joined to the command decoder
`timescale 1ns/1ps
`include "fcd_defs.svh"
`default_nettype none
module floppy_command_decoder_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [7:0] paddr, disk_rd_data, disk_wr_data, dlt;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] drive_sel;
  logic head_sel, step_pulse, step_inward, drv_write_protect, drv_ready, drv_track0;
  logic disk_rd_valid, disk_rd_ready, disk_wr_valid;
  logic [7:0] hb [128];
  logic [7:0] ops [4] = '{8'hFD, 8'hF9, 8'h45, 8'h56};
  logic [7:0] prm [6] = '{8'h03, 8'h01, 8'h04, 8'h00, 8'h09, 8'h1B};
  logic [7:0] exp_q [$];
  int err_total, num_checks, seed, dk, wk, s_in, s_out, sent;
  fcd_link_if lnk();
  fcd_host i_fcd_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(lnk));
  fcd_device #(.STEP_UNIT_CYC(2)) i_fcd_device(.pclk(pclk), .presetn(presetn), .link(lnk),
    .drive_sel(drive_sel), .head_sel(head_sel), .step_pulse(step_pulse),
    .step_inward(step_inward), .drv_write_protect(drv_write_protect), .drv_ready(drv_ready),
    .drv_track0(drv_track0), .disk_rd_valid(disk_rd_valid), .disk_rd_data(disk_rd_data),
    .disk_rd_ready(disk_rd_ready), .disk_wr_valid(disk_wr_valid), .disk_wr_data(disk_wr_data));
  fcd_link_monitor i_fcd_link_monitor(.pclk(pclk), .presetn(presetn), .byte_wr(lnk.byte_wr),
    .wr_data(lnk.wr_data), .byte_rd(lnk.byte_rd), .extended_track_range(lnk.extended_track_range), .rd_data(lnk.rd_data),
    .main_status(lnk.main_status), .dma_req(lnk.dma_req), .int_pending(lnk.int_pending));
  // 50 MHz clock
  always #10 pclk = ~pclk;
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    close_out();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 40) hang();
  endtask
  // Poll the status register until the masked bits match
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `FCD_REG_STATUS, 32'h0);
      n++;
    end while ((q & m) !== v && n < 3000);
    if (n >= 3000) hang();
  endtask
  task automatic wb(input logic [7:0] b);
    wait_st(32'hC0, 32'h80);
    apb(1'b1, `FCD_REG_DATA, {24'h0, b});
  endtask
  // Compare results with the model queue, then look for surplus bytes
  task automatic results(input bit strict);
    while (exp_q.size() > 0) begin
      wait_st(32'hC0, 32'hC0);
      apb(1'b0, `FCD_REG_DATA, 32'h0);
      chk(q, {24'h0, exp_q.pop_front()});
    end
    apb(1'b0, `FCD_REG_STATUS, 32'h0);
    if (strict) chk({31'h0, q[6]}, 32'h0);
  endtask
  // Host side of the execution phase: feed bytes while asked
  task automatic exec_phase;
    int n;
    sent = 0;
    n = 0;
    do begin
      apb(1'b0, `FCD_REG_STATUS, 32'h0);
      n++;
      if (q[7:5] == 3'b101 || q[8]) begin
        apb(1'b1, `FCD_REG_DATA, {24'h0, hb[sent % 128]});
        sent++;
      end
    end while (q[7:6] != 2'b11 && n < 3000);
    if (n >= 3000) hang();
  endtask
  // Disk side: stream read bytes, count steps, check written bytes
  always @(posedge pclk) begin
    if (disk_rd_ready === 1'b1 && disk_rd_valid === 1'b1) dk = dk + 1;
    disk_rd_data <= hb[dk % 128] + dlt;
    if (step_pulse === 1'b1 && step_inward === 1'b1) s_in++;
    if (step_pulse === 1'b1 && step_inward !== 1'b1) s_out++;
    if (disk_wr_valid === 1'b1) begin
      chk({24'h0, disk_wr_data}, {24'h0, hb[wk % 128]});
      wk++;
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {drv_write_protect, drv_ready, drv_track0, dlt} = '0;
    disk_rd_valid = 1'b1;
    {err_total, num_checks, dk, wk, s_in, s_out} = '0;
    seed = 42551;
    for (int i = 0; i < 128; i++) hb[i] = 8'($unsigned($random(seed)) % 255);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FCD_REG_STATUS, 32'h0);
    chk(q, 32'h80);
    apb(1'b0, 8'h14, 32'h0);
    chk(q + 32'(serr), 32'h1);
    // Refused read, then interrupt raise, mask and clear
    apb(1'b0, `FCD_REG_DATA, 32'h0);
    apb(1'b0, `FCD_REG_IRQ_STAT, 32'h0);
    chk(q & 32'h8, 32'h8);
    wb(`FCD_OP_SENSE_INT);
    wait_st(32'hC0, 32'hC0);
    apb(1'b1, `FCD_REG_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `FCD_REG_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `FCD_REG_IRQ_MASK, 32'h1);
    apb(1'b0, `FCD_REG_IRQ_STAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    exp_q = '{8'h80, 8'h00};
    results(1'b1);
    // Specify: fast steps, non-DMA, silent
    wb(`FCD_OP_SPECIFY);
    wb(8'hF0);
    wb(8'h01);
    results(1'b1);
    // Set track written, then read back
    for (int k = 0; k < 2; k++) begin
      wb(k ? 8'h21 : 8'h61);
      wb(8'h31);
      wb(k ? 8'hAA : 8'h05);
      exp_q.push_back(8'h05);
      results(1'b1);
    end
    // Seek inward with extended range, then outward without
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `FCD_REG_CFG, 32'(1 - k));
      {s_in, s_out} = '0;
      wb(`FCD_OP_SEEK);
      wb(8'h01);
      wb(k ? 8'h03 : 8'h0A);
      if (k == 0) wb(8'h00);
      results(1'b1);
      wait_st(32'h200, 32'h200);
      chk(32'(s_in), k ? 0 : 5);
      chk(32'(s_out), k ? 7 : 0);
      chk({30'h0, drive_sel}, 32'h1);
      wb(`FCD_OP_SENSE_INT);
      exp_q = '{8'h21, k ? 8'h03 : 8'h0A};
      if (k == 0) exp_q.push_back(8'h00);
      results(1'b1);
    end
    // Drive status with random pins and junk in ignored bits
    for (int k = 0; k < 2; k++) begin
      {drv_write_protect, drv_ready, drv_track0} <= 3'($random(seed));
      repeat (4) @(posedge pclk);
      wb(`FCD_OP_SENSE_DRV);
      wb(8'h06 | 8'(k << 3));
      exp_q.push_back({1'b0, drv_write_protect, drv_ready, drv_track0, 4'b0110});
      results(1'b1);
    end
    // Scan high, scan low unmet, write, verify two sectors
    for (int k = 0; k < 4; k++) begin
      dlt = (k == 1) ? 8'h01 : 8'h00;
      if (k == 2) begin
        wb(`FCD_OP_SPECIFY);
        wb(8'hF0);
        wb(8'h00);
      end
      {dk, wk} = '0;
      wb(ops[k]);
      wb(k == 3 ? 8'hFE : 8'h7E);
      foreach (prm[i]) wb(prm[i]);
      wb(k == 3 ? 8'h02 : 8'h01);
      exec_phase();
      chk(32'(sent), k == 3 ? 0 : 128);
      chk(32'(dk), k == 2 ? 0 : (k == 3 ? 256 : 128));
      chk(32'(wk), k == 2 ? 128 : 0);
      exp_q = '{8'h06, 8'h00, k == 0 ? 8'h08 : (k == 1 ? 8'h04 : 8'h00), 8'h03, 8'h01, 8'h04, 8'h00};
      results(1'b1);
    end
    close_out();
  end
endmodule
`default_nettype wire
